// ### core/spsc_pkg.sv
// Constants, register map and types of the standby pin state control block.
package spsc_pkg;
   localparam int          NPINS        = 16;
   localparam logic [11:0] ADDR_CTRL    = 12'h000;
   localparam logic [11:0] ADDR_STAT    = 12'h004;
   localparam logic [11:0] ADDR_MASK    = 12'h008;
   localparam logic [11:0] ADDR_PULLUP  = 12'h00C;
   localparam logic [11:0] ADDR_IRQEN   = 12'h010;
   localparam int          CTRL_SEL_BIT = 0;
   localparam int          CTRL_WAKE_BIT = 1;
   localparam int          STAT_EXT_BIT = 0;
   localparam int          STAT_CMP_BIT = 1;
   localparam int          STAT_I2C_BIT = 2;
   localparam int          NEVT         = 3;
   localparam logic [31:0] ZERO32       = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      MODE_NORMAL = 2'b00,
      MODE_SLEEP  = 2'b01,
      MODE_STOP   = 2'b10,
      MODE_WATCH  = 2'b11
   } spsc_mode_e;

   typedef struct packed
   {
      logic [11:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } spsc_apb_req_s;

   typedef struct packed
   {
      logic [NPINS-1:0] out;
      logic [NPINS-1:0] oe;
   } spsc_pin_drv_s;
endpackage : spsc_pkg

// ### core/spsc_top.sv
// Standby pin state control: pin gating per operating mode, APB registers, wake events.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module spsc_top
#(
   parameter int NP = spsc_pkg::NPINS
)
(
   input  wire logic                  REF_CLK_I,
   input  wire logic                  RST_N_I,
   input  wire spsc_pkg::spsc_apb_req_s APB_REQ_I,
   output logic [31:0]                APB_PRDATA_O,
   output logic                       APB_PREADY_O,
   output logic                       APB_PSLVERR_O,
   input  wire spsc_pkg::spsc_mode_e  MODE_I,
   input  wire spsc_pkg::spsc_pin_drv_s FUNC_DRV_I,
   input  wire logic [NP-1:0]         PIN_IN_I,
   output logic [NP-1:0]              PIN_OUT_O,
   output logic [NP-1:0]              PIN_OE_O,
   output logic [NP-1:0]              PIN_PULLUP_O,
   output logic [NP-1:0]              CORE_IN_O,
   input  wire logic [NP-1:0]         EXT_IRQ_CAP_I,
   output logic [NP-1:0]              EXT_IRQ_IN_O,
   input  wire logic [NP-1:0]         CMP_IN_CAP_I,
   output logic [NP-1:0]              CMP_IN_EN_O,
   input  wire logic [NP-1:0]         CMP_OUT_CAP_I,
   input  wire logic [NP-1:0]         CMP_OUT_VAL_I,
   input  wire logic                  CMP_IRQ_I,
   input  wire logic                  I2C_WAKE_REQ_I,
   output logic                       WAKE_O,
   output logic                       IRQ_O
);
   import spsc_pkg::*;

   initial
   begin
      if (NP < 1 || NP > 32)
      begin
         $error("NP must lie between 1 and 32.");
      end
   end

   logic [NP-1:0] pin_meta_ff;
   logic [NP-1:0] pin_sync_ff;
   logic [NP-1:0] hold_out_ff;
   logic [NP-1:0] hold_oe_ff;
   logic [NP-1:0] pullup_ff;
   logic [NP-1:0] irqen_ff;
   logic          sel_ff;
   logic          wake_en_ff;
   logic [NEVT-1:0] stat_ff;
   logic [NEVT-1:0] mask_ff;
   logic [NEVT-1:0] nxt_stat;
   logic [NEVT-1:0] evt;
   logic [NP-1:0] ext_prev_ff;
   logic          cmp_prev_ff;
   logic          i2c_prev_ff;
   logic [NP-1:0] nxt_out;
   logic [NP-1:0] nxt_oe;
   logic [NP-1:0] nxt_core;
   logic [NP-1:0] nxt_ext;
   logic [NP-1:0] nxt_cmp;
   logic          standby;
   logic          in_reset;
   logic          wr_en;
   logic          rd_en;
   logic [31:0]   rd_data;
   logic          mapped;

   function automatic logic [31:0] spsc_pad(input logic [NP-1:0] v);
      logic [31:0] r;
      r = ZERO32;
      r[NP-1:0] = v;
      return r;
   endfunction : spsc_pad

   assign standby  = (MODE_I == MODE_STOP) || (MODE_I == MODE_WATCH);
   assign in_reset = !RST_N_I;
   // Writes and read-clears act only at the edge that completes the access, so a
   // request that is still standing in its wait cycle cannot act twice.
   assign wr_en    = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite && APB_PREADY_O;
   assign rd_en    = APB_REQ_I.psel && APB_REQ_I.penable && !APB_REQ_I.pwrite && APB_PREADY_O;

   // Pins come from the board, so two stages precede any reader.
   always_ff @(posedge REF_CLK_I)
   begin
      pin_meta_ff <= PIN_IN_I;
      pin_sync_ff <= pin_meta_ff;
   end

   // The drive captured outside standby is what a held pin keeps showing.
   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         hold_out_ff <= '0;
         hold_oe_ff  <= '0;
      end
      else if (!standby)
      begin
         hold_out_ff <= FUNC_DRV_I.out;
         hold_oe_ff  <= FUNC_DRV_I.oe;
      end
   end

   always_comb
   begin
      nxt_out  = FUNC_DRV_I.out;
      nxt_oe   = FUNC_DRV_I.oe;
      nxt_core = pin_sync_ff;
      nxt_ext  = pin_sync_ff & EXT_IRQ_CAP_I;
      nxt_cmp  = CMP_IN_CAP_I;
      if (standby)
      begin
         nxt_core = '0;
         nxt_ext  = pin_sync_ff & EXT_IRQ_CAP_I & irqen_ff;
         nxt_cmp  = CMP_IN_CAP_I;
         if (sel_ff)
         begin
            nxt_out = '0;
            nxt_oe  = '0;
         end
         else
         begin
            nxt_out = hold_out_ff;
            nxt_oe  = hold_oe_ff;
         end
         nxt_out = (nxt_out & ~CMP_OUT_CAP_I) | (CMP_OUT_VAL_I & CMP_OUT_CAP_I);
         nxt_oe  = nxt_oe | CMP_OUT_CAP_I;
      end
   end

   // Reset releases every driver and pull-up, and blocks the core, interrupt and comparator input paths.
   always_ff @(posedge REF_CLK_I)
   begin
      if (in_reset)
      begin
         PIN_OUT_O    <= '0;
         PIN_OE_O     <= '0;
         CORE_IN_O    <= '0;
         EXT_IRQ_IN_O <= '0;
         CMP_IN_EN_O  <= '0;
         PIN_PULLUP_O <= '0;
      end
      else
      begin
         PIN_OUT_O    <= nxt_out;
         PIN_OE_O     <= nxt_oe;
         CORE_IN_O    <= nxt_core;
         EXT_IRQ_IN_O <= nxt_ext;
         CMP_IN_EN_O  <= nxt_cmp;
         PIN_PULLUP_O <= pullup_ff;
      end
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         sel_ff     <= 1'b0;
         wake_en_ff <= 1'b0;
         mask_ff    <= '0;
         pullup_ff  <= '0;
         irqen_ff   <= '0;
      end
      else if (wr_en)
      begin
         unique case (APB_REQ_I.paddr)
            ADDR_CTRL:
            begin
               sel_ff     <= APB_REQ_I.pwdata[CTRL_SEL_BIT];
               wake_en_ff <= APB_REQ_I.pwdata[CTRL_WAKE_BIT];
            end
            ADDR_MASK:   mask_ff   <= APB_REQ_I.pwdata[NEVT-1:0];
            ADDR_PULLUP: pullup_ff <= APB_REQ_I.pwdata[NP-1:0];
            ADDR_IRQEN:  irqen_ff  <= APB_REQ_I.pwdata[NP-1:0];
            default:     sel_ff    <= sel_ff;
         endcase
      end
   end

   // Wake events are rising edges seen only while in standby.
   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         ext_prev_ff <= '0;
         cmp_prev_ff <= 1'b0;
         i2c_prev_ff <= 1'b0;
      end
      else
      begin
         ext_prev_ff <= nxt_ext;
         cmp_prev_ff <= CMP_IRQ_I;
         i2c_prev_ff <= I2C_WAKE_REQ_I;
      end
   end

   always_comb
   begin
      evt               = '0;
      evt[STAT_EXT_BIT] = standby && |(nxt_ext & ~ext_prev_ff);
      evt[STAT_CMP_BIT] = standby && CMP_IRQ_I && !cmp_prev_ff;
      evt[STAT_I2C_BIT] = standby && wake_en_ff && I2C_WAKE_REQ_I && !i2c_prev_ff;
      nxt_stat          = stat_ff;
      if (rd_en && APB_REQ_I.paddr == ADDR_STAT)
      begin
         nxt_stat = '0;
      end
      // A new event in the clearing cycle survives the read.
      nxt_stat = nxt_stat | evt;
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         stat_ff <= '0;
         IRQ_O   <= 1'b0;
         WAKE_O  <= 1'b0;
      end
      else
      begin
         stat_ff <= nxt_stat;
         IRQ_O   <= |(nxt_stat & mask_ff);
         WAKE_O  <= |evt;
      end
   end

   always_comb
   begin
      rd_data = ZERO32;
      mapped  = 1'b1;
      unique case (APB_REQ_I.paddr)
         ADDR_CTRL:
         begin
            rd_data[CTRL_SEL_BIT]  = sel_ff;
            rd_data[CTRL_WAKE_BIT] = wake_en_ff;
         end
         ADDR_STAT:   rd_data[NEVT-1:0] = stat_ff;
         ADDR_MASK:   rd_data[NEVT-1:0] = mask_ff;
         ADDR_PULLUP: rd_data = spsc_pad(pullup_ff);
         ADDR_IRQEN:  rd_data = spsc_pad(irqen_ff);
         default:     mapped  = 1'b0;
      endcase
   end

   // Ready is registered, so every access takes one wait cycle.
   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         APB_PREADY_O  <= 1'b0;
         APB_PRDATA_O  <= ZERO32;
         APB_PSLVERR_O <= 1'b0;
      end
      else
      begin
         APB_PREADY_O  <= APB_REQ_I.psel && APB_REQ_I.penable && !APB_PREADY_O;
         APB_PRDATA_O  <= rd_data;
         APB_PSLVERR_O <= APB_REQ_I.psel && APB_REQ_I.penable && !APB_PREADY_O && !mapped;
      end
   end
endmodule : spsc_top
`default_nettype wire

// ### testbench/spsc_checker.sv
// Port assertions for the standby pin state control block.
`timescale 1ns/10ps
`default_nettype none
module spsc_checker
   import spsc_pkg::*;
#(
   parameter int NP = NPINS
)
(
   input wire logic          REF_CLK_I,
   input wire logic          RST_N_I,
   input wire spsc_apb_req_s APB_REQ_I,
   input wire logic          APB_PREADY_O,
   input wire spsc_mode_e    MODE_I,
   input wire spsc_pin_drv_s FUNC_DRV_I,
   input wire logic [NP-1:0] PIN_OUT_O,
   input wire logic [NP-1:0] PIN_OE_O,
   input wire logic [NP-1:0] PIN_PULLUP_O,
   input wire logic [NP-1:0] CORE_IN_O,
   input wire logic [NP-1:0] CMP_OUT_CAP_I,
   input wire logic [NP-1:0] CMP_OUT_VAL_I,
   input wire logic          WAKE_O
);
   logic [2:0]    rs_ff;
   logic          sb_ff;
   logic          sel_ff;
   logic [NP-1:0] pu_ff;
   logic          wr;
   logic          live;
   logic [NP-1:0] co;
   assign co = CMP_OUT_CAP_I;
   assign live = &rs_ff;
   assign wr = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite & APB_PREADY_O;
   // Shadows move on the write edge itself, so they never lag the real registers.
   always_ff @(posedge REF_CLK_I)
   begin
      rs_ff <= {rs_ff[1:0], RST_N_I};
      sb_ff <= MODE_I[1];
      if (!RST_N_I)
      begin
         sel_ff <= 1'b0;
         pu_ff <= '0;
      end
      else if (wr && APB_REQ_I.paddr == ADDR_CTRL)
         sel_ff <= APB_REQ_I.pwdata[CTRL_SEL_BIT];
      else if (wr && APB_REQ_I.paddr == ADDR_PULLUP)
         pu_ff <= APB_REQ_I.pwdata[NP-1:0];
   end
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   AST_RST_OFF:
   assert property (disable iff (1'b0) !rs_ff[0] |-> PIN_OE_O == '0 && CORE_IN_O == '0)
      else $error("reset pins");
   AST_NORM:
   assert property (live && !sb_ff |-> PIN_OE_O == $past(FUNC_DRV_I.oe)
      && PIN_OUT_O == $past(FUNC_DRV_I.out)) else $error("drive lost");
   AST_BLOCK:
   assert property (live && sb_ff |-> CORE_IN_O == '0) else $error("input open");
   AST_HIZ:
   assert property (live && sb_ff && $past(sel_ff) |-> (PIN_OE_O & ~co) == '0)
      else $error("pin driven");
   AST_HOLD:
   assert property (live && sb_ff && $past(sb_ff) && !$past(sel_ff, 2) && !$past(sel_ff)
      |-> $stable(PIN_OE_O) && $stable(PIN_OUT_O & ~co)) else $error("hold moved");
   AST_PULLUP:
   assert property ($stable(pu_ff)[*3] |-> PIN_PULLUP_O == pu_ff) else $error("pull-up");
   AST_CMP_OUT:
   assert property (live && sb_ff |-> (PIN_OE_O & co) == co
      && (PIN_OUT_O & co) == ($past(CMP_OUT_VAL_I) & co)) else $error("cmp out");
   AST_WAKE:
   assert property (WAKE_O |-> sb_ff ##1 !WAKE_O) else $error("wake pulse");
   COV_WAKE: cover property (MODE_I == MODE_STOP && WAKE_O);
   COV_HIZ: cover property (MODE_I == MODE_WATCH && sel_ff);
   COV_SLEEP: cover property (MODE_I == MODE_SLEEP);
endmodule : spsc_checker
`default_nettype wire

// ### testbench/spsc_board.sv
// Board model that settles every pad level.
`timescale 1ns/10ps
`default_nettype none
module spsc_board
(
   input  wire logic [15:0] out_i,
   input  wire logic [15:0] oe_i,
   input  wire logic [15:0] pu_i,
   input  wire logic [15:0] ext_i,
   output logic [15:0]      pad_o
);
   // A released pad never floats: the pull-up or the board level decides it.
   assign pad_o = (oe_i & out_i) | (~oe_i & (pu_i | ext_i));
endmodule : spsc_board
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the standby pin state control block.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import spsc_pkg::*;
   localparam logic [15:0] CO = 16'h0400;
   localparam logic [15:0] PU = 16'h000F;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          cirq = 1'b0;
   logic          i2c = 1'b0;
   logic          rdy, err, wake, irq;
   logic [15:0]   ext = '0;
   logic [15:0]   cval = '0;
   logic [15:0]   pad, po, poe, ppu, cin, xin, cen;
   logic [31:0]   prd, r;
   logic          e;
   spsc_apb_req_s req = '0;
   spsc_mode_e    mode = MODE_NORMAL;
   spsc_pin_drv_s fd = '0;
   int            mismatches = 0;
   int            checked = 0;
   int            wakes = 0;
   logic [49:0]   rows [4] = '{{MODE_NORMAL, 48'hA5A5_FF00_1230}, {MODE_SLEEP, 48'h5A5A_00FF_C000},
      {MODE_SLEEP, 48'hFFFF_FFFF_0000}, {MODE_NORMAL, 48'h0000_0F0F_F0F0}};
   always #25 clk = ~clk;
   always @(negedge clk)
      wakes += int'(wake === 1'b1);
   spsc_top dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .APB_REQ_I(req), .APB_PRDATA_O(prd),
      .APB_PREADY_O(rdy), .APB_PSLVERR_O(err), .MODE_I(mode), .FUNC_DRV_I(fd), .PIN_IN_I(pad),
      .PIN_OUT_O(po), .PIN_OE_O(poe), .PIN_PULLUP_O(ppu), .CORE_IN_O(cin), .EXT_IRQ_CAP_I(16'h00F0),
      .EXT_IRQ_IN_O(xin), .CMP_IN_CAP_I(16'h0300), .CMP_IN_EN_O(cen), .CMP_OUT_CAP_I(CO),
      .CMP_OUT_VAL_I(cval), .CMP_IRQ_I(cirq), .I2C_WAKE_REQ_I(i2c), .WAKE_O(wake), .IRQ_O(irq));
   spsc_board brd_u (.out_i(po), .oe_i(poe), .pu_i(ppu), .ext_i(ext), .pad_o(pad));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic go(input int n);
      repeat (n) @(negedge clk);
   endtask : go
   // The request stays up until the rising edge after pready is seen high at a falling edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do
         go(1);
      while (rdy !== 1'b1);
      r = prd;
      e = err;
      @(posedge clk);
      req <= '0;
   endtask : apb
   task automatic test_done();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   initial
   begin
      go(6);
      chk(poe | cin, '0);
      @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b1, ADDR_PULLUP, 32'(PU));
      apb(1'b1, ADDR_IRQEN, 32'h10);
      apb(1'b1, ADDR_MASK, 32'h3);
      apb(1'b0, ADDR_PULLUP, '0);
      chk(r[15:0], PU);
      apb(1'b0, 12'h014, 32'hFFFF_FFFF);
      chk({e, r[14:0]}, 16'h8000);
      foreach (rows[i])
      begin
         @(posedge clk);
         mode <= spsc_mode_e'(rows[i][49:48]);
         fd <= rows[i][47:16];
         ext <= rows[i][15:0];
         go(6);
         chk(po, rows[i][47:32]);
         chk(poe, rows[i][31:16]);
         chk(cin, rows[i][47:32] & rows[i][31:16] | ~rows[i][31:16] & (PU | rows[i][15:0]));
      end
      @(posedge clk);
      mode <= MODE_STOP;
      cval <= 16'hFFFF;
      go(2);
      @(posedge clk);
      fd <= '1;
      go(6);
      chk(poe, 16'h0F0F | CO);
      chk(po, CO);
      chk(cin | (cen ^ 16'h0300), '0);
      apb(1'b0, ADDR_STAT, '0);
      @(posedge clk);
      ext <= '0;
      go(6);
      chk(xin, '0);
      @(posedge clk);
      ext <= 16'hF0F0;
      go(6);
      chk({xin[15:1], irq}, 16'h0011);
      apb(1'b0, ADDR_STAT, '0);
      chk(r[15:0], 16'h0001);
      apb(1'b1, ADDR_CTRL, 32'h2);
      wakes = 0;
      @(posedge clk);
      i2c <= 1'b1;
      go(4);
      chk(16'(wakes) | 16'(irq), 16'h1);
      apb(1'b0, ADDR_STAT, '0);
      chk(r[15:0], 16'h0004);
      @(posedge clk);
      cirq <= 1'b1;
      go(4);
      chk(16'(irq), 16'h1);
      apb(1'b0, ADDR_STAT, '0);
      chk(r[15:0], 16'h0002);
      go(2);
      chk(16'(irq), 16'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      @(posedge clk);
      mode <= MODE_WATCH;
      go(3);
      chk(poe | (ppu ^ PU) | cin, CO);
      test_done();
   end
   initial
   begin
      #100000;
      mismatches++;
      test_done();
   end
endmodule : tb
bind spsc_top spsc_checker #(.NP(NP)) chk_u (.*);
`default_nettype wire
